// File: verilog/mppt_regs_pkg.sv
package mppt_regs_pkg;

    // ****************************************
    // register map and bus framing
    // ****************************************
    localparam int REG_W = 56;
    localparam int REG_BYTES = 7;
    localparam logic [7:0] CMD_BASE = 8'he0;
    localparam logic [1:0] REG_CFG = 2'h0;
    localparam logic [1:0] REG_MEAS = 2'h1;
    localparam logic [1:0] REG_UNUSED = 2'h2;
    localparam logic [1:0] REG_CTRL = 2'h3;
    localparam logic [3:0] ADDR_HI = 4'h0;
    localparam int CFG_PAD_W = 16;
    localparam int MEAS_PAD_W = 15;

    // ****************************************
    // field layouts
    // ****************************************
    typedef struct packed {
        logic [9:0] slew_setting_channel;
        logic [9:0] current_ceiling_channel;
        logic [9:0] operating_mode_channel;
        logic [9:0] voltage_ceiling_channel;
    } adc_cfg_s;

    typedef struct packed {
        logic [9:0] vout;
        logic [9:0] iout;
        logic [9:0] vin;
        logic [9:0] iin;
    } meas_s;

    typedef struct packed {
        logic [8:0] rsvd_hi;
        logic adc_override;
        logic rsvd_45;
        logic [1:0] rsvd_44_43;
        logic power_thr_sel;
        logic [1:0] buck_boost_dwell_select;
        logic [9:0] iout_max;
        logic [9:0] vout_max;
        logic [2:0] dead_off;
        logic [2:0] dead_on;
        logic [8:0] open_loop_duty;
        logic pass_sel;
        logic pass_manual;
        logic converter_soft_reset;
        logic clk_out_en;
        logic open_loop;
    } ctrl_reg_s;

    typedef struct packed {
        logic power_thr_sel;
        logic [1:0] buck_boost_dwell_select;
        logic [9:0] iout_max;
        logic [9:0] vout_max;
    } settings_s;

    // ****************************************
    // reset values
    // ****************************************
    localparam ctrl_reg_s CTRL_RST = '{
        rsvd_hi: 9'h0, adc_override: 1'b0, rsvd_45: 1'b0, rsvd_44_43: 2'h1,
        power_thr_sel: 1'b0, buck_boost_dwell_select: 2'h0,
        iout_max: 10'h3ff, vout_max: 10'h3ff, dead_off: 3'h3, dead_on: 3'h3,
        open_loop_duty: 9'h0ff, pass_sel: 1'b0, pass_manual: 1'b0,
        converter_soft_reset: 1'b0, clk_out_en: 1'b0, open_loop: 1'b0};

    // ****************************************
    // serial slave states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_RACK = 3'b100
    } slave_st_e;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_CMD = 2'b01,
        PH_DATA = 2'b10
    } byte_ph_e;

endpackage

// File: verilog/bit_sync.sv
// two-stage synchroniser; no reset so pin levels are valid at release
module bit_sync #(
    parameter int W = 1
) (
    // clock
    input wire logic ref_clk_i,
    // asynchronous levels and their synchronised copies
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_i) begin
        meta_r <= async_i;
        sync_o <= meta_r;
    end
endmodule

// File: verilog/mppt_config_register_bank.sv
// Operation
// - a read-only register returns the four configuration adc results in bits 39:0, zero at reset.
// - a read-only register returns bit 40 tracking start and the four measurements in bits 39:0.
// - control bit 46 makes the control fields replace the adc-derived settings.
// - under override, control bit 42 replaces mode channel bit 9 as the power threshold select.
// - under override, control bits 41:40 replace mode channel bits 8:7, reset zero.
// - under override, control bits 39:30 give the output current ceiling, reset 1023.
// - under override, control bits 29:20 give the output voltage ceiling, reset 1023.
// - control bit 4 makes the manual panel-mode bit replace the panel-mode pin, both reset zero.
// - while bit 4 is set, control bit 3 directly commands panel mode.
// - control bit 0 disables tracking and drives the duty from bits 13:5, reset 0xff.
// - control bit 1 routes the pll clock to its output pin, otherwise the pin stays low.
// - serial clock and data are only ever pulled low, a high comes from the external pull-up.
// - every register is 56 bits moved as seven bytes, least significant byte first.
// - the low three slave address bits are taken from the three address straps, the upper four are zero.
module mppt_config_register_bank (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // serial bus pins, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_b_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_b_o,
    // straps and pins
    input wire logic address_strap_0_i,
    input wire logic address_strap_1_i,
    input wire logic address_strap_2_i,
    input wire logic panel_mode_force_pin_b_i,
    input wire logic pll_clk_i,
    output logic pll_clk_o,
    // internal converter status
    input wire mppt_regs_pkg::adc_cfg_s adc_i,
    input wire mppt_regs_pkg::meas_s meas_i,
    input wire logic tracking_start_i,
    // settings to the converter logic
    output mppt_regs_pkg::settings_s settings_o,
    output logic panel_mode_o,
    output logic open_loop_o,
    output logic [8:0] open_loop_duty_o,
    output logic [2:0] dead_off_o,
    output logic [2:0] dead_on_o,
    output logic converter_soft_reset_o
);
    import mppt_regs_pkg::*;

    typedef struct packed {
        slave_st_e st;
        byte_ph_e ph;
        logic [3:0] bitc;
        logic [2:0] bytec;
        logic [7:0] sh;
        logic [REG_W-1:0] rbuf;
        logic [REG_W-1:0] wbuf;
        logic [1:0] sel;
        logic rd;
        logic ack;
        logic sda_oe_b;
        logic scl_q;
        logic sda_q;
        logic strap_ld;
        logic [2:0] addr;
        ctrl_reg_s ctrl;
        adc_cfg_s cfg_snap;
        settings_s set;
        logic panel;
        logic pll_out;
    } bank_state_s;

    bank_state_s s_r;
    bank_state_s s_nxt;
    logic [6:0] sync_v;
    logic scl_s, sda_s, pm_b_s, pll_s;
    logic [2:0] strap_s;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [7:0] tx_byte;
    logic [REG_W-1:0] wr_word;

    // ****************************************
    // pin synchronisers
    // ****************************************
    bit_sync #(.W(7)) u_sync (
        .ref_clk_i(ref_clk_i),
        .async_i({scl_i, sda_i, panel_mode_force_pin_b_i, pll_clk_i,
                  address_strap_2_i, address_strap_1_i, address_strap_0_i}),
        .sync_o(sync_v)
    );
    assign {scl_s, sda_s, pm_b_s, pll_s, strap_s} = sync_v;

    // bus events; start and stop need scl high in both samples
    assign scl_rise = scl_s & ~s_r.scl_q;
    assign scl_fall = ~scl_s & s_r.scl_q;
    assign bus_start = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s;
    assign bus_stop = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s;
    assign tx_byte = s_r.rbuf[7:0];
    assign wr_word = {s_r.sh, s_r.wbuf[REG_W-1:8]}; // bytes enter from the top

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.scl_q = scl_s;
        s_nxt.sda_q = sda_s;
        // straps are caught once, on the first cycle after release
        if (!s_r.strap_ld) begin
            s_nxt.addr = strap_s;
            s_nxt.strap_ld = 1'b1;
        end
        // settings follow the override bit every cycle
        s_nxt.cfg_snap = adc_i;
        if (s_r.ctrl.adc_override) begin
            s_nxt.set.power_thr_sel = s_r.ctrl.power_thr_sel;
            s_nxt.set.buck_boost_dwell_select = s_r.ctrl.buck_boost_dwell_select;
            s_nxt.set.iout_max = s_r.ctrl.iout_max;
            s_nxt.set.vout_max = s_r.ctrl.vout_max;
        end else begin
            s_nxt.set.power_thr_sel = adc_i.operating_mode_channel[9];
            s_nxt.set.buck_boost_dwell_select = adc_i.operating_mode_channel[8:7];
            s_nxt.set.iout_max = adc_i.current_ceiling_channel;
            s_nxt.set.vout_max = adc_i.voltage_ceiling_channel;
        end
        // pin is active low; the manual bit takes over when selected
        s_nxt.panel = s_r.ctrl.pass_sel ? s_r.ctrl.pass_manual : ~pm_b_s;
        s_nxt.pll_out = s_r.ctrl.clk_out_en & pll_s;
        // slave engine: bits are taken on scl rise and changed on scl fall
        case (s_r.st)
            ST_RX: begin
                if (scl_rise && s_r.bitc != 4'h8) begin
                    s_nxt.sh = {s_r.sh[6:0], sda_s};
                    s_nxt.bitc = s_r.bitc + 4'h1;
                end else if (scl_fall && s_r.bitc == 4'h8) begin
                    s_nxt.bitc = 4'h0;
                    s_nxt.st = ST_ACK;
                    s_nxt.ack = 1'b0;
                    case (s_r.ph)
                        PH_ADDR: begin
                            if (s_r.sh[7:1] == {ADDR_HI, s_r.addr}) begin
                                s_nxt.ack = 1'b1;
                                s_nxt.rd = s_r.sh[0];
                                case (s_r.sel)
                                    REG_CFG: s_nxt.rbuf = {{CFG_PAD_W{1'b0}}, s_r.cfg_snap};
                                    REG_MEAS: s_nxt.rbuf = {{MEAS_PAD_W{1'b0}}, tracking_start_i,
                                                            meas_i};
                                    default: s_nxt.rbuf = s_r.ctrl;
                                endcase
                            end
                        end
                        PH_CMD: begin
                            if (s_r.sh[7:2] == CMD_BASE[7:2] && s_r.sh[1:0] != REG_UNUSED) begin
                                s_nxt.ack = 1'b1;
                                s_nxt.sel = s_r.sh[1:0];
                            end
                        end
                        default: begin
                            // only the control register takes data, and only seven bytes
                            if (s_r.sel == REG_CTRL && s_r.bytec != 3'h7) begin
                                s_nxt.ack = 1'b1;
                                s_nxt.wbuf = wr_word;
                                s_nxt.bytec = s_r.bytec + 3'h1;
                                if (s_r.bytec == 3'h6) begin
                                    s_nxt.ctrl = wr_word;
                                end
                            end
                        end
                    endcase
                    s_nxt.sda_oe_b = ~s_nxt.ack;
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    if (!s_r.ack) begin
                        s_nxt.st = ST_IDLE;
                        s_nxt.sda_oe_b = 1'b1;
                    end else if (s_r.ph == PH_ADDR && s_r.rd) begin
                        s_nxt.st = ST_TX;
                        s_nxt.bitc = 4'h1;
                        s_nxt.sda_oe_b = tx_byte[7]; // a zero is sent by pulling low
                    end else begin
                        s_nxt.st = ST_RX;
                        s_nxt.sda_oe_b = 1'b1;
                        s_nxt.ph = (s_r.ph == PH_ADDR) ? PH_CMD : PH_DATA;
                    end
                end
            end
            ST_TX: begin
                if (scl_fall) begin
                    if (s_r.bitc == 4'h8) begin
                        s_nxt.st = ST_RACK;
                        s_nxt.bitc = 4'h0;
                        s_nxt.sda_oe_b = 1'b1;
                    end else begin
                        s_nxt.sda_oe_b = tx_byte[3'h7 - s_r.bitc[2:0]];
                        s_nxt.bitc = s_r.bitc + 4'h1;
                    end
                end
            end
            ST_RACK: begin
                if (scl_rise) begin
                    s_nxt.ack = ~sda_s;
                end else if (scl_fall) begin
                    // next byte only on a master ack and while bytes remain
                    if (s_r.ack && s_r.bytec != 3'(REG_BYTES - 1)) begin
                        s_nxt.rbuf = {8'h00, s_r.rbuf[REG_W-1:8]};
                        s_nxt.bytec = s_r.bytec + 3'h1;
                        s_nxt.st = ST_TX;
                        s_nxt.bitc = 4'h1;
                        s_nxt.sda_oe_b = s_r.rbuf[15];
                    end else begin
                        s_nxt.st = ST_IDLE;
                    end
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
        // start and stop override anything in progress
        if (bus_start) begin
            s_nxt.st = ST_RX;
            s_nxt.ph = PH_ADDR;
            s_nxt.bitc = 4'h0;
            s_nxt.bytec = 3'h0;
            s_nxt.rd = 1'b0;
            s_nxt.sda_oe_b = 1'b1;
        end else if (bus_stop) begin
            s_nxt.st = ST_IDLE;
            s_nxt.sda_oe_b = 1'b1;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.sda_oe_b <= 1'b1;
            // idle bus levels, so release never shows a false clock or data edge
            s_r.scl_q <= 1'b1;
            s_r.sda_q <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs come straight from the state register; scl_o, scl_oe_b_o and sda_o are constants
    assign scl_o = 1'b0; // clock is never stretched
    assign scl_oe_b_o = 1'b1;
    assign sda_o = 1'b0;
    assign sda_oe_b_o = s_r.sda_oe_b;
    assign pll_clk_o = s_r.pll_out;
    assign settings_o = s_r.set;
    assign panel_mode_o = s_r.panel;
    assign open_loop_o = s_r.ctrl.open_loop;
    assign open_loop_duty_o = s_r.ctrl.open_loop_duty;
    assign dead_off_o = s_r.ctrl.dead_off;
    assign dead_on_o = s_r.ctrl.dead_on;
    assign converter_soft_reset_o = s_r.ctrl.converter_soft_reset;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence seq_last_byte;
        s_r.st == ST_RX && s_r.ph == PH_DATA && s_r.sel == REG_CTRL && s_r.bytec == 3'h6;
    endsequence
    sequence seq_byte_taken;
        scl_fall && s_r.bitc == 4'h8;
    endsequence

    chk_cfg_snapshot: assert property (
        $past(rst_b_i) |-> s_r.cfg_snap == $past(adc_i))
        else $error("config snapshot lags adc input");
    chk_iout_source: assert property (
        $past(rst_b_i) |-> settings_o.iout_max == ($past(s_r.ctrl.adc_override)
        ? $past(s_r.ctrl.iout_max) : $past(adc_i.current_ceiling_channel)))
        else $error("current ceiling from wrong source");
    chk_vout_source: assert property (
        $past(s_r.ctrl.adc_override) |-> settings_o.vout_max == $past(s_r.ctrl.vout_max))
        else $error("voltage ceiling not overridden");
    chk_thr_source: assert property (
        $past(rst_b_i) && !$past(s_r.ctrl.adc_override)
        |-> settings_o.power_thr_sel == $past(adc_i.operating_mode_channel[9]))
        else $error("power threshold not from mode channel");
    chk_dwell_source: assert property (
        $past(s_r.ctrl.adc_override) |-> settings_o.buck_boost_dwell_select
        == $past(s_r.ctrl.buck_boost_dwell_select)) else $error("dwell select not overridden");
    chk_panel_manual: assert property (
        $past(s_r.ctrl.pass_sel) |-> panel_mode_o == $past(s_r.ctrl.pass_manual))
        else $error("panel mode ignores manual bit");
    chk_panel_pin: assert property (
        !$past(s_r.ctrl.pass_sel) |-> panel_mode_o == !$past(pm_b_s))
        else $error("panel mode ignores pin");
    chk_clk_gate: assert property (
        !$past(s_r.ctrl.clk_out_en) |-> !pll_clk_o) else $error("pll clock leaks out");
    chk_ctrl_reset: assert property (
        $rose(rst_b_i) |-> open_loop_duty_o == 9'h0ff && !open_loop_o && s_r.ctrl == CTRL_RST)
        else $error("control register reset value wrong");
    chk_ctrl_commit: assert property (
        (seq_last_byte and seq_byte_taken) |=> s_r.ctrl == $past(wr_word) && s_r.st == ST_ACK)
        else $error("seventh byte did not commit");
    chk_line_release: assert property (
        $rose(bus_stop) |=> sda_oe_b_o && scl_oe_b_o) else $error("line held after stop");
endmodule

// File: dv/i2c_host_model.sv
module i2c_host_model (
    // clock
    input wire logic ref_clk_i,
    // resolved data wire level
    input wire logic sda_i,
    // pull-down enables, low while the host pulls the wire
    output logic scl_oe_b_o,
    output logic sda_oe_b_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // bus master, 125 ns per bit
    // ****************************************
    // idle bus: both wires released to the pull-up
    initial begin
        scl_oe_b_o = 1'b1;
        sda_oe_b_o = 1'b1;
    end

    // steps land just after a reference edge so sampling never races them
    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // 13 cycles low, 12 high, one fixed rate for every transfer
    // data moves only while the clock is low
    task automatic clock_bit(input logic b, output logic seen);
        ticks(6);
        sda_oe_b_o = b; // a one is a release, the pull-up gives the level
        ticks(7);
        scl_oe_b_o = 1'b1;
        ticks(6);
        seen = sda_i;
        ticks(6);
        scl_oe_b_o = 1'b0;
    endtask

    // start, also used as repeated start with the clock low
    task automatic start();
        ticks(6);
        sda_oe_b_o = 1'b1;
        ticks(7);
        scl_oe_b_o = 1'b1;
        ticks(6);
        sda_oe_b_o = 1'b0;
        ticks(6);
        scl_oe_b_o = 1'b0;
    endtask

    task automatic stop();
        ticks(6);
        sda_oe_b_o = 1'b0;
        ticks(7);
        scl_oe_b_o = 1'b1;
        ticks(6);
        sda_oe_b_o = 1'b1;
        ticks(6);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], s);
        end
        clock_bit(1'b1, s);
        ack = !s;
    endtask

    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(!ack, s);
    endtask

    // whole register, seven bytes low byte first; counts the slave's acks
    task automatic write_reg(input logic [6:0] adr, input logic [7:0] cmd,
                             input logic [55:0] d, output int acks);
        logic a;
        acks = 0;
        start();
        send_byte({adr, 1'b0}, a);
        acks += int'(a);
        send_byte(cmd, a);
        acks += int'(a);
        for (int i = 0; i < 7; i++) begin
            send_byte(d[8*i +: 8], a);
            acks += int'(a);
        end
        stop();
    endtask

    task automatic read_reg(input logic [6:0] adr, input logic [7:0] cmd,
                            output logic [55:0] d, output int acks);
        logic a;
        acks = 0;
        start();
        send_byte({adr, 1'b0}, a);
        acks += int'(a);
        send_byte(cmd, a);
        acks += int'(a);
        start();
        send_byte({adr, 1'b1}, a);
        acks += int'(a);
        for (int i = 0; i < 7; i++) begin
            recv_byte(i < 6, d[8*i +: 8]); // last byte refused
        end
        stop();
    endtask
endmodule

// File: dv/mppt_config_register_bank_bench.sv
module mppt_config_register_bank_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import mppt_regs_pkg::*;

    logic ref_clk, rst_b, pin_b, pll_in, trk, pll_out, panel, open_loop, soft_rst;
    logic scl_o, scl_oe_b, sda_o, sda_oe_b, h_scl_oe_b, h_sda_oe_b;
    logic [2:0] strap, dead_off, dead_on;
    logic [8:0] duty;
    logic [6:0] adr;
    logic [55:0] ctrl_m;
    adc_cfg_s adc;
    meas_s meas;
    settings_s settings;
    int mismatches = 0;
    int tests_run = 0;
    // open-drain wires with pull-ups: released means high
    wire scl_w = h_scl_oe_b & (scl_oe_b | scl_o);
    wire sda_w = h_sda_oe_b & (sda_oe_b | sda_o);

    mppt_config_register_bank i_mppt_config_register_bank (
        .ref_clk_i(ref_clk), .rst_b_i(rst_b), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_b_o(scl_oe_b), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b),
        .address_strap_0_i(strap[0]), .address_strap_1_i(strap[1]),
        .address_strap_2_i(strap[2]), .panel_mode_force_pin_b_i(pin_b),
        .pll_clk_i(pll_in), .pll_clk_o(pll_out), .adc_i(adc), .meas_i(meas),
        .tracking_start_i(trk), .settings_o(settings), .panel_mode_o(panel),
        .open_loop_o(open_loop), .open_loop_duty_o(duty), .dead_off_o(dead_off),
        .dead_on_o(dead_on), .converter_soft_reset_o(soft_rst));

    i2c_host_model i_i2c_host_model (
        .ref_clk_i(ref_clk), .sda_i(sda_w), .scl_oe_b_o(h_scl_oe_b),
        .sda_oe_b_o(h_sda_oe_b));

    // ****************************************
    // clocks, checks and verdict
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // unrelated clock slower than the reference, only its resampled copy is seen
    initial begin
        pll_in = 1'b0;
        forever #11.7 pll_in = ~pll_in;
    end

    task automatic cmp_val(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hung transfer would otherwise never end the run
    initial begin
        #400us;
        mismatches++;
        stop_test();
    end

    // the device may only ever pull its pins low
    always @(negedge ref_clk) begin
        if (rst_b === 1'b1) begin
            cmp_val("pin drive", 3'b100, {scl_oe_b, scl_o, sda_o});
        end
    end

    function automatic logic [7:0] cmd_of(input logic [1:0] r);
        return CMD_BASE + {6'h0, r};
    endfunction

    // the 40-cycle watch also covers every output's settle latency
    task automatic check_outs();
        int rises;
        logic prev;
        logic [22:0] es;
        es = ctrl_m[46] ? ctrl_m[42:20] : {adc.operating_mode_channel[9:7],
            adc.current_ceiling_channel, adc.voltage_ceiling_channel};
        rises = 0;
        prev = pll_out;
        repeat (40) begin
            @(posedge ref_clk);
            #1;
            if (pll_out === 1'b1 && prev === 1'b0) rises++;
            prev = pll_out;
        end
        cmp_val("clock output", ctrl_m[1], rises > 0);
        cmp_val("settings", es, settings);
        cmp_val("panel mode", ctrl_m[4] ? ctrl_m[3] : !pin_b, panel);
        cmp_val("open loop", {ctrl_m[0], ctrl_m[13:5]}, {open_loop, duty});
        cmp_val("dead times", ctrl_m[19:14], {dead_off, dead_on});
        cmp_val("soft reset", ctrl_m[2], soft_rst);
    endtask

    task automatic put_ctrl(input logic [55:0] d);
        int acks;
        logic [55:0] rd;
        i_i2c_host_model.write_reg(adr, cmd_of(REG_CTRL), d, acks);
        cmp_val("write acks", 9, acks);
        ctrl_m = d;
        i_i2c_host_model.read_reg(adr, cmd_of(REG_CTRL), rd, acks);
        cmp_val("control readback", ctrl_m, rd);
        check_outs();
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int acks;
        logic [55:0] rd;
        logic [55:0] w;
        void'($urandom(7));
        rst_b = 1'b0;
        pin_b = 1'b1;
        trk = 1'b1;
        strap = 3'($urandom_range(7, 1));
        adr = {ADDR_HI, strap};
        {adc, meas} = 80'({$urandom(), $urandom(), $urandom()});
        ctrl_m = CTRL_RST;
        repeat (3) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        check_outs();
        i_i2c_host_model.read_reg(adr, cmd_of(REG_CTRL), rd, acks);
        cmp_val("control reset", CTRL_RST, rd);
        i_i2c_host_model.read_reg(adr, cmd_of(REG_CFG), rd, acks);
        cmp_val("config readback", {16'h0, adc}, rd);
        i_i2c_host_model.read_reg(adr, cmd_of(REG_MEAS), rd, acks);
        cmp_val("measurement readback", {15'h0, trk, meas}, rd);
        cmp_val("read acks", 3, acks);
        // the tracking flag must follow its input both ways
        trk = 1'b0;
        meas = 40'({$urandom(), $urandom()});
        i_i2c_host_model.read_reg(adr, cmd_of(REG_MEAS), rd, acks);
        cmp_val("measurement flag low", {15'h0, trk, meas}, rd);
        // refused transfers leave the control word alone
        i_i2c_host_model.write_reg(adr ^ 7'h08, cmd_of(REG_CTRL), '1, acks);
        cmp_val("foreign address acks", 0, acks);
        i_i2c_host_model.write_reg(adr ^ 7'h01, cmd_of(REG_CTRL), '1, acks);
        cmp_val("foreign strap acks", 0, acks);
        i_i2c_host_model.write_reg(adr, cmd_of(REG_UNUSED), '1, acks);
        cmp_val("bad command acks", 1, acks);
        i_i2c_host_model.write_reg(adr, cmd_of(REG_CFG), '1, acks);
        cmp_val("read-only write acks", 2, acks);
        i_i2c_host_model.read_reg(adr, cmd_of(REG_CTRL), rd, acks);
        cmp_val("control untouched", CTRL_RST, rd);
        // random words, override off and on, fresh adc values each time
        for (int i = 0; i < 4; i++) begin
            adc = 40'({$urandom(), $urandom()});
            w = 56'({$urandom(), $urandom()});
            w[46] = i[0];
            put_ctrl(w);
        end
        // every pass-through setting against both pin levels
        for (int k = 0; k < 4; k++) begin
            w = CTRL_RST;
            w[4:3] = 2'(k);
            put_ctrl(w);
            pin_b = 1'b0;
            check_outs();
            pin_b = 1'b1;
        end
        // open-loop entry: enable, then pulse the soft reset
        w = CTRL_RST;
        w[1:0] = 2'h3;
        w[13:5] = 9'($urandom());
        put_ctrl(w);
        w[2] = 1'b1;
        put_ctrl(w);
        w[2] = 1'b0;
        put_ctrl(w);
        stop_test();
    end
endmodule
